// >>> design/xmb_regs.vh
// Constants for the external memory bus interface of the core.
// Assumes a single core clock; the bus timing is counted in core clock periods.
`ifndef XMB_REGS_VH
`define XMB_REGS_VH
`define XMB_SLOT_CYCLES   3'h6
`define XMB_SLOT_LAST     3'h5
`define XMB_PH_ADDR       3'h0
`define XMB_PH_LATCH      3'h1
`define XMB_PH_STROBE     3'h2
`define XMB_PH_SAMPLE     3'h4
`define XMB_INT_CODE_TOP  24'h00_1FFF
`define XMB_LSD_BIT       4
`define XMB_ZERO8         8'h00
`define XMB_ONES8         8'hFF
`define XMB_ZERO24        24'h00_0000
`define XMB_CMD_FETCH     2'h0
`define XMB_CMD_READ      2'h1
`define XMB_CMD_WRITE     2'h2
`define XMB_BUF_DEPTH     2
`endif

// >>> design/xmb_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall at any time; no word is lost while full.
module xmb_buf2
(
  // Clock and reset.
  input  wire        mclk_i,
  input  wire        reset_i,
  // Fill side.
  input  wire        in_valid_i,
  output wire        in_ready_o,
  input  wire [8:0]  in_data_i,
  // Drain side.
  output wire        out_valid_o,
  input  wire        out_ready_i,
  output wire [8:0]  out_data_o
);
  reg  [8:0] mem_q [0:1];
  reg        wr_q;
  reg        rd_q;
  reg  [1:0] cnt_q;
  wire       push;
  wire       pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 9'h000;
      mem_q[1] <= 9'h000;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

// >>> design/xmb_bus.v
// External memory bus: fetches code and reads or writes the 24-bit external data space.
// Assumes an external address latch and memories on the muxed port; one external access per eight clocks at most.
// Operation
// [R1] Write pulses the write strobe while the data byte sits on the low port.
// [R2] Read asserts read strobe; memory drives low port; device captures byte.
// [R3] External fetch puts address bits 15 to 8 on the upper port.
// [R4] Data access puts middle then high address byte on the upper port.
// [R5] Upper pins carry bits 8-11/16-19 low nibble, 12-15/20-23 high nibble.
// [R6] Idle upper port is a pulled-up general port; a written 1 reads as input.
// [R7] External-access select is sampled when reset ends and latches execution mode.
// [R8] Select high: 0000H-1FFFH fetched internally; low: all fetches go external.
// [R9] Outside party keeps the select pin constant during normal operation.
// [R10] Program-store strobe enables external program memory during external fetches.
// [R11] Program-store strobe fires every six clocks except during data accesses; the code fires it only in external fetch slots, once per fetch.
// [R12] Program-store strobe stays high while executing from internal memory.
// [R13] Program-store pin low at reset release enters serial download mode.
// [R14] Latch strobe captures low address byte, and page byte for data accesses; the code never drives the page byte while the strobe is high.
// [R15] Latch strobe fires every six clocks except during data accesses; the code pulses it once per external access, data accesses included.
// [R16] Power control bit 4 set stops driving the latch strobe.
// [R17] Low port carries low address byte first, then the data byte.
// [R18] Low port drives ones strongly while acting as memory bus.
// [R19] As general port the low port is open-drain; written ones float.
// [R20] Software writes no ones to reserved control bits.
// [R21] Data address is page byte, high byte, low byte of the pointer.
// [R22] Low address precedes latch strobe fall; data phase follows under strobes.
`include "xmb_regs.vh"

module xmb_bus
(
  // Clock and reset.
  input  wire        mclk_i,
  input  wire        reset_i,
  // Core request side.
  input  wire        req_valid_i,
  output wire        req_ready_o,
  input  wire [1:0]  req_cmd_i,
  input  wire [7:0]  data_pointer_page_byte_i,
  input  wire [7:0]  data_pointer_high_byte_i,
  input  wire [7:0]  data_pointer_low_byte_i,
  input  wire [7:0]  req_wdata_i,
  // Core answer side.
  output wire        rsp_valid_o,
  input  wire        rsp_ready_i,
  output wire [7:0]  rsp_data_o,
  output wire        rsp_internal_o,
  // Mode and control.
  input  wire [7:0]  power_control_register_i,
  input  wire [7:0]  upper_port_latch_i,
  input  wire [7:0]  low_port_latch_i,
  output reg         code_external_o,
  output reg         serial_download_o,
  // Straps.
  input  wire        external_access_select_i,
  // Program-store strobe, two-way for the download strap.
  input  wire        program_store_strobe_i,
  output reg         program_store_strobe_o,
  output reg         program_store_strobe_oe_o,
  // Address latch strobe.
  output reg         addr_latch_strobe_o,
  output reg         addr_latch_strobe_oe_o,
  // Read and write strobes, active low.
  output reg         rd_n_o,
  output reg         wr_n_o,
  // Multiplexed low address and data port.
  input  wire [7:0]  muxed_addr_data_lines_i,
  output reg  [7:0]  muxed_addr_data_lines_o,
  output reg  [7:0]  muxed_addr_data_lines_oe_o,
  // Upper address port.
  input  wire [7:0]  upper_address_port_i,
  output reg  [7:0]  upper_address_port_o,
  output reg  [7:0]  upper_address_port_oe_o
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_DATA  = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  ph_q;
  reg  [1:0]  cmd_q;
  reg  [23:0] addr_q;
  reg  [7:0]  wdata_q;
  reg         strap_q;
  reg  [7:0]  cap_q;
  reg         cap_int_q;
  reg         cap_valid_q;
  wire        buf_ready;
  wire [8:0]  buf_out;
  wire        slot_end;
  wire        go_ext;
  wire        take;
  wire [23:0] req_addr;
  wire [7:0]  gp_low_oe;
  wire [7:0]  gp_up_oe;

  // Names the fetch command once for both the routing and the state choice.
  function is_fetch;
    input [1:0] cmd;
    begin
      is_fetch = (cmd == `XMB_CMD_FETCH);
    end
  endfunction

  // Slot phases before the strobe phase still show the address on both ports.
  function in_addr_phase;
    input [2:0] ph;
    begin
      in_addr_phase = (ph < `XMB_PH_STROBE);
    end
  endfunction

  // Decides whether a fetch leaves the chip; data accesses always do.
  function is_external;
    input [1:0]  cmd;
    input [23:0] addr;
    input        code_ext;
    begin
      is_external = ~is_fetch(cmd) | code_ext | (addr > `XMB_INT_CODE_TOP); // [R8]
    end
  endfunction

  assign req_addr = {data_pointer_page_byte_i, data_pointer_high_byte_i, data_pointer_low_byte_i}; // [R21]
  assign slot_end = (ph_q == `XMB_SLOT_LAST);
  // A pending answer stalls the bus so a stalled receiver never loses a byte.
  // A request in the strap cycle is refused, so every access sees the settled mode.
  assign req_ready_o = (state_q == ST_IDLE) & ~cap_valid_q & buf_ready & ~strap_q;
  assign take = req_valid_i & req_ready_o;
  assign go_ext = is_external(req_cmd_i, req_addr, code_external_o);

  // Idle ports drive only written zeros: open-drain low pins float, pulled-up upper pins read back.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_gp
      assign gp_low_oe[gi] = ~low_port_latch_i[gi]; // [R19]
      assign gp_up_oe[gi]  = ~upper_port_latch_i[gi]; // [R6]
    end
  endgenerate

  // Strap capture in the first clocked cycle after reset ends.
  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      strap_q           <= 1'b1;
      code_external_o   <= 1'b0;
      serial_download_o <= 1'b0;
    end
    else if (strap_q)
    begin
      strap_q           <= 1'b0;
      code_external_o   <= ~external_access_select_i; // [R7] [R9]
      serial_download_o <= ~program_store_strobe_i; // [R13]
    end
  end

  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_q     <= ST_IDLE;
      ph_q        <= `XMB_PH_ADDR;
      cmd_q       <= `XMB_CMD_FETCH;
      addr_q      <= `XMB_ZERO24;
      wdata_q     <= `XMB_ZERO8;
      cap_q       <= `XMB_ZERO8;
      cap_int_q   <= 1'b0;
      cap_valid_q <= 1'b0;
    end
    else
    begin
      if (cap_valid_q & buf_ready)
        cap_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          ph_q <= `XMB_PH_ADDR;
          if (take & ~strap_q)
          begin
            cmd_q   <= req_cmd_i;
            addr_q  <= req_addr;
            wdata_q <= req_wdata_i;
            if (go_ext)
              state_q <= is_fetch(req_cmd_i) ? ST_FETCH : ST_DATA;
            else
            begin
              // Internal code is not modelled here; the core supplies it and only a marker returns.
              cap_q       <= `XMB_ZERO8;
              cap_int_q   <= 1'b1;
              cap_valid_q <= 1'b1;
            end
          end
        end
        ST_FETCH, ST_DATA:
        begin
          ph_q <= slot_end ? `XMB_PH_ADDR : ph_q + 3'h1;
          // Memory has driven the port for two clocks by the sample phase, so the byte is settled.
          if ((ph_q == `XMB_PH_SAMPLE) & (cmd_q != `XMB_CMD_WRITE))
            cap_q <= muxed_addr_data_lines_i; // [R2]
          if (slot_end)
          begin
            cap_int_q   <= 1'b0;
            cap_valid_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin drive, registered so every pin output comes from a flip-flop.
  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      program_store_strobe_o     <= 1'b1;
      program_store_strobe_oe_o  <= 1'b0;
      addr_latch_strobe_o        <= 1'b0;
      addr_latch_strobe_oe_o     <= 1'b0;
      rd_n_o                     <= 1'b1;
      wr_n_o                     <= 1'b1;
      muxed_addr_data_lines_o    <= `XMB_ZERO8;
      muxed_addr_data_lines_oe_o <= `XMB_ZERO8;
      upper_address_port_o       <= `XMB_ONES8;
      upper_address_port_oe_o    <= `XMB_ZERO8;
    end
    else
    begin
      // The strap pin is released until sampled, then driven high when idle.
      program_store_strobe_oe_o <= ~strap_q; // [R12]
      program_store_strobe_o    <= 1'b1; // [R12]
      addr_latch_strobe_oe_o    <= ~power_control_register_i[`XMB_LSD_BIT]; // [R16]
      addr_latch_strobe_o       <= 1'b0;
      rd_n_o                    <= 1'b1;
      wr_n_o                    <= 1'b1;
      // General port: open-drain low port, ones float. [R19]
      muxed_addr_data_lines_o    <= `XMB_ZERO8;
      muxed_addr_data_lines_oe_o <= gp_low_oe; // [R19]
      // Pulled-up upper port: only zeros are driven, ones read back as inputs. [R6]
      upper_address_port_o       <= `XMB_ZERO8;
      upper_address_port_oe_o    <= gp_up_oe; // [R6]
      // Slot phases 0 and 1 show the address; phases 2 to 5 carry the strobe and the data.
      if (state_q != ST_IDLE)
      begin
        upper_address_port_oe_o <= `XMB_ONES8;
        if (state_q == ST_FETCH)
          upper_address_port_o <= addr_q[15:8]; // [R3] [R5]
        else
          upper_address_port_o <= in_addr_phase(ph_q) ? addr_q[15:8] : addr_q[23:16]; // [R4] [R5]
        // The latch takes the low byte; for data it pulses only at the request, before the page byte goes out. [R14]
        addr_latch_strobe_o <= (ph_q == `XMB_PH_ADDR) & (state_q == ST_FETCH); // [R15] [R14]
        muxed_addr_data_lines_oe_o <= `XMB_ONES8; // [R18]
        if (in_addr_phase(ph_q))
          muxed_addr_data_lines_o <= addr_q[7:0]; // [R17] [R22]
        else if (state_q == ST_FETCH)
        begin
          muxed_addr_data_lines_oe_o <= `XMB_ZERO8; // [R22]
          program_store_strobe_o     <= slot_end; // [R10] [R11]
        end
        else if (cmd_q == `XMB_CMD_WRITE)
        begin
          muxed_addr_data_lines_o <= wdata_q; // [R17]
          wr_n_o                  <= slot_end; // [R1]
        end
        else
        begin
          muxed_addr_data_lines_oe_o <= `XMB_ZERO8; // [R2]
          rd_n_o                     <= slot_end; // [R2]
        end
      end
      else if (take & go_ext)
      begin
        // The address goes out with the first latch pulse, so the latch never captures a port value.
        addr_latch_strobe_o        <= 1'b1; // [R14] [R15]
        muxed_addr_data_lines_o    <= req_addr[7:0]; // [R17] [R22]
        muxed_addr_data_lines_oe_o <= `XMB_ONES8; // [R18]
        upper_address_port_o       <= req_addr[15:8]; // [R3] [R4] [R5]
        upper_address_port_oe_o    <= `XMB_ONES8;
      end
    end
  end

  // The buffer decouples answers from the pins, so a stalled core never freezes a slot.
  xmb_buf2 u_buf
  (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (cap_valid_q),
    .in_ready_o  (buf_ready),
    .in_data_i   ({cap_int_q, cap_q}),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  (buf_out)
  );

  assign rsp_data_o     = buf_out[7:0];
  assign rsp_internal_o = buf_out[8];
endmodule

// >>> dv/xmb_mem_model.sv
// External program and data memory behind an address latch, facing the muxed bus.
// Assumes the bench resolves the shared wires; index mixes all address bytes to catch byte-order slips.
module xmb_mem_model
(
  // Bus strobes and lines.
  input  wire       mclk_i,
  input  wire       ale_i,
  input  wire       program_store_strobe_n_i,
  input  wire       rd_n_i,
  input  wire       wr_n_i,
  input  wire [7:0] ad_i,
  input  wire [7:0] up_i,
  // Memory drive onto the low port.
  output wire       drv_o,
  output wire [7:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  wire  [7:0] idx = lo_q ^ hi_q ^ {up_i[3:0], up_i[7:4]};
  initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
  always @(posedge mclk_i)
  begin
    if (ale_i)
    begin
      lo_q <= ad_i;
      hi_q <= up_i;
    end
    if (!wr_n_i) mem[idx] <= ad_i;
  end
  assign drv_o = !program_store_strobe_n_i || !rd_n_i;
  assign dat_o = mem[idx];
endmodule

// >>> dv/xmb_bus_chk.sv
// Timing checker for the external memory bus pins.
// Assumes it is bound to the bus top and sees only its ports.
module xmb_bus_chk
(
  input wire       mclk_i,
  input wire       reset_i,
  input wire       rsp_valid_o,
  input wire       rsp_ready_i,
  input wire [7:0] rsp_data_o,
  input wire [7:0] power_control_register_i,
  input wire       program_store_strobe_o,
  input wire       addr_latch_strobe_o,
  input wire       addr_latch_strobe_oe_o,
  input wire       rd_n_o,
  input wire       wr_n_o,
  input wire [7:0] muxed_addr_data_lines_oe_o,
  input wire [7:0] upper_address_port_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_wr_drive: assert property (!wr_n_o |-> muxed_addr_data_lines_oe_o == 8'hFF)
    else $error("write phase low port not driven");
  a_rd_release: assert property (!rd_n_o |-> muxed_addr_data_lines_oe_o == 8'h00)
    else $error("read phase low port still driven");
  a_fetch_release: assert property (!program_store_strobe_o |-> muxed_addr_data_lines_oe_o == 8'h00)
    else $error("fetch phase low port still driven");
  a_ale_addr: assert property (addr_latch_strobe_o |-> (muxed_addr_data_lines_oe_o & upper_address_port_oe_o) == 8'hFF)
    else $error("latch strobe without address driven");
  a_ale_gate: assert property (!$past(reset_i) |-> addr_latch_strobe_oe_o == !$past(power_control_register_i[4]))
    else $error("latch strobe enable wrong");
  a_fetch_order: assert property ($fell(program_store_strobe_o) |-> $past(addr_latch_strobe_o, 2))
    else $error("fetch strobe without latch strobe");
  a_rd_len: assert property ($fell(rd_n_o) |-> !rd_n_o [*3] ##1 rd_n_o)
    else $error("read strobe length wrong");
  a_wr_len: assert property ($fell(wr_n_o) |-> !wr_n_o [*3] ##1 wr_n_o)
    else $error("write strobe length wrong");
  a_one_strobe: assert property ($onehot0({~rd_n_o, ~wr_n_o, ~program_store_strobe_o}))
    else $error("strobes overlap");
  a_data_no_ale: assert property (($fell(rd_n_o) || $fell(wr_n_o)) |-> !addr_latch_strobe_o [*4])
    else $error("latch strobe inside data slot");
  a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o))
    else $error("answer dropped while stalled");
  c_write: cover property ($fell(wr_n_o));
  c_read: cover property ($fell(rd_n_o));
  c_fetch: cover property ($fell(program_store_strobe_o));
  c_stall: cover property (rsp_valid_o && !rsp_ready_i);
endmodule
bind xmb_bus xmb_bus_chk chk_u (.*);

// >>> dv/xmb_bus_bench.sv
// Self-checking bench for the external memory bus.
// Assumes a memory model on the far side and pull-ups on released lines.
module xmb_bus_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] c; logic [23:0] a; logic [7:0] w; logic [7:0] d; logic i;} xmb_row_t;
  xmb_row_t   rows [6];
  int         n_fail = 0;
  int         n_checks = 0;
  logic       mclk_i = 0, reset_i = 1, req_valid_i = 0, rsp_ready_i = 1, external_access_select_i = 1, ps_strap = 1;
  logic [1:0] req_cmd_i = 0;
  logic [7:0] data_pointer_page_byte_i = 0, data_pointer_high_byte_i = 0, data_pointer_low_byte_i = 0;
  logic [7:0] req_wdata_i = 0, power_control_register_i = 0, upper_port_latch_i = 8'hF0, low_port_latch_i = 8'h0F;
  wire        req_ready_o, rsp_valid_o, rsp_internal_o, code_external_o, serial_download_o, mdrv;
  wire        program_store_strobe_o, program_store_strobe_oe_o, addr_latch_strobe_o, addr_latch_strobe_oe_o;
  wire        rd_n_o, wr_n_o;
  wire  [7:0] rsp_data_o, muxed_addr_data_lines_o, muxed_addr_data_lines_oe_o, mdat;
  wire  [7:0] upper_address_port_o, upper_address_port_oe_o;
  wire        program_store_strobe_i = program_store_strobe_oe_o ? program_store_strobe_o : ps_strap;
  wire  [7:0] upper_address_port_i = upper_address_port_o & upper_address_port_oe_o | ~upper_address_port_oe_o;
  wire  [7:0] muxed_addr_data_lines_i = muxed_addr_data_lines_o & muxed_addr_data_lines_oe_o
                                      | ~muxed_addr_data_lines_oe_o & (mdrv ? mdat : 8'hFF);
  always #50 mclk_i = ~mclk_i;
  xmb_bus dut_u (.*);
  xmb_mem_model mem_u (.mclk_i(mclk_i), .ale_i(addr_latch_strobe_o & addr_latch_strobe_oe_o),
    .program_store_strobe_n_i(program_store_strobe_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_i(muxed_addr_data_lines_i),
    .up_i(upper_address_port_i), .drv_o(mdrv), .dat_o(mdat));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rst;
    reset_i = 1;
    repeat (6) tick;
    reset_i = 0;
    tick;
  endtask
  task automatic send(input logic [1:0] c, input logic [23:0] a, input logic [7:0] w);
    int i;
    {data_pointer_page_byte_i, data_pointer_high_byte_i, data_pointer_low_byte_i} = a;
    req_cmd_i = c;
    req_wdata_i = w;
    req_valid_i = 1;
    for (i = 0; i < 50 && req_ready_o !== 1'b1; i++) tick;
    if (i == 50)
    begin
      n_fail++;
      conclude;
    end
    tick;
    req_valid_i = 0;
    tick;
  endtask
  task automatic get(input logic [7:0] d, input logic in, input logic dchk);
    int i;
    for (i = 0; i < 50 && rsp_valid_o !== 1'b1; i++) tick;
    if (i == 50)
    begin
      n_fail++;
      conclude;
    end
    chk("internal", {7'h00, rsp_internal_o}, {7'h00, in});
    if (dchk) chk("data", rsp_data_o, d);
    tick;
  endtask
  initial
  begin
    rows = '{'{2'h2, 24'h12_3456, 8'hA5, 8'h00, 1'b0}, '{2'h1, 24'h12_3456, 8'h00, 8'hA5, 1'b0},
             '{2'h1, 24'hAB_CD07, 8'h00, 8'h8F, 1'b0}, '{2'h0, 24'h00_0100, 8'h00, 8'h00, 1'b1},
             '{2'h0, 24'h00_1FFF, 8'h00, 8'h00, 1'b1}, '{2'h0, 24'h00_2010, 8'h00, 8'hCD, 1'b0}};
    rst;
    chk("upper oe", upper_address_port_oe_o, ~upper_port_latch_i);
    chk("low oe", muxed_addr_data_lines_oe_o, ~low_port_latch_i);
    chk("mode", {6'h00, code_external_o, serial_download_o}, 8'h00);
    foreach (rows[k])
    begin
      send(rows[k].c, rows[k].a, rows[k].w);
      get(rows[k].d, rows[k].i, rows[k].c != 2'h2);
    end
    $display("table done");
    rsp_ready_i = 0;
    send(2'h0, 24'h00_0100, 8'h00);
    send(2'h0, 24'h00_0101, 8'h00);
    repeat (4) tick;
    chk("refuse", {7'h00, req_ready_o}, 8'h00);
    rsp_ready_i = 1;
    get(8'h00, 1'b1, 1'b1);
    get(8'h00, 1'b1, 1'b1);
    $display("stall done");
    power_control_register_i = 8'h10;
    repeat (2) tick;
    chk("ale oe", {7'h00, addr_latch_strobe_oe_o}, 8'h00);
    power_control_register_i = 8'h00;
    $display("latch gate done");
    external_access_select_i = 0;
    ps_strap = 0;
    rst;
    chk("mode", {6'h00, code_external_o, serial_download_o}, 8'h03);
    send(2'h0, 24'h00_0100, 8'h00);
    get(8'hEE, 1'b0, 1'b1);
    $display("strap done");
    conclude;
  end
endmodule
